// ### sbcf_map.svh
// counts, widths and timing constants of the bank command state machine
`ifndef SBCF_MAP_SVH
`define SBCF_MAP_SVH
`define SBCF_NUM_BANKS              4
`define SBCF_TIMER_W                8
`define SBCF_CLK_PERIOD_NS          8
`define SBCF_PRECHARGE_TIME_NS      24
`define SBCF_ACT_TO_ACCESS_TIME_NS  24
`define SBCF_REFRESH_CYCLE_TIME_NS  80
`define SBCF_MODE_LOAD_DELAY_NS     16
`define SBCF_SR_EXIT_TIME_NS        120
`define SBCF_WRITE_RECOVERY_NS      16
`define SBCF_CYC(ns) (((ns) + `SBCF_CLK_PERIOD_NS - 1) / `SBCF_CLK_PERIOD_NS)
`define SBCF_PRECHARGE_CYC     `SBCF_CYC(`SBCF_PRECHARGE_TIME_NS)
`define SBCF_ACT_TO_ACCESS_CYC `SBCF_CYC(`SBCF_ACT_TO_ACCESS_TIME_NS)
`define SBCF_REFRESH_CYC       `SBCF_CYC(`SBCF_REFRESH_CYCLE_TIME_NS)
`define SBCF_MODE_LOAD_CYC     `SBCF_CYC(`SBCF_MODE_LOAD_DELAY_NS)
`define SBCF_SR_EXIT_CYC       `SBCF_CYC(`SBCF_SR_EXIT_TIME_NS)
`define SBCF_WRITE_RECOVERY_CYC `SBCF_CYC(`SBCF_WRITE_RECOVERY_NS)
`define SBCF_CAS_PIPE_DEPTH    3
`endif

// ### sbcf_pkg.sv
// types shared by the bank command state machine
package sbcf_pkg;
    typedef enum logic [3:0] {
        CMD_INHIBIT, CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE, CMD_BTERM,
        CMD_PRECHARGE, CMD_REFRESH, CMD_LOAD_MODE
    } sbcf_cmd_t;
    typedef enum logic [2:0] {
        BS_IDLE, BS_ACTIVATING, BS_ROW_ACTIVE, BS_READ, BS_WRITE,
        BS_READ_AP, BS_WRITE_AP, BS_PRECHARGING
    } sbcf_bank_state_t;
    typedef enum logic [1:0] {
        GS_NORMAL, GS_REFRESHING, GS_MODE_ACCESS, GS_SR_EXIT_WAIT
    } sbcf_glob_state_t;
    typedef struct packed {
        logic       cke;
        logic       cs_b;
        logic       ras_b;
        logic       cas_b;
        logic       we_b;
        logic [1:0] ba;
        logic       a10;
    } sbcf_cmd_bus_t;
    typedef struct packed {
        logic all_idle;
        logic refreshing;
        logic mode_access;
        logic sr_exit_wait;
        logic decode_en;
    } sbcf_status_t;
endpackage : sbcf_pkg

// ### sbcf_timer.sv
// down counter timing one bank or shared interval
`timescale 1ns/1ns
`default_nettype none
`include "sbcf_map.svh"
module sbcf_timer (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_b,
    input  wire logic                     load,
    input  wire logic [`SBCF_TIMER_W-1:0] load_val,
    output logic                          expire
);
    logic [`SBCF_TIMER_W-1:0] count_reg;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= load_val;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    // high in the last cycle of the interval; the owner moves on at the next edge
    assign expire = (count_reg == `SBCF_TIMER_W'(1)) && !load;
endmodule : sbcf_timer
`default_nettype wire

// ### sbcf_bank.sv
// state machine of one bank with its own interval timer
`timescale 1ns/1ns
`default_nettype none
`include "sbcf_map.svh"
module sbcf_bank (
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic              decode_en,
    input  wire sbcf_pkg::sbcf_cmd_t cmd,
    input  wire logic              hit,
    input  wire logic              auto_pre,
    input  wire logic              pre_all,
    input  wire logic              other_burst,
    input  wire logic              burst_done,
    output sbcf_pkg::sbcf_bank_state_t state,
    output logic                   illegal
);
    sbcf_pkg::sbcf_bank_state_t state_reg, state_next;
    logic                       ap_pre_reg, ap_start;
    logic                       load, t_done, exec_hit, rw_hit, pre_cmd;
    logic [`SBCF_TIMER_W-1:0]   load_val;

    sbcf_timer u_timer (              // private timer per bank
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .load     (load),
        .load_val (load_val),
        .expire   (t_done)
    );

    always_comb begin
        pre_cmd  = decode_en && (cmd == sbcf_pkg::CMD_PRECHARGE) && (hit || pre_all);
        rw_hit   = decode_en && hit && (cmd == sbcf_pkg::CMD_READ || cmd == sbcf_pkg::CMD_WRITE);
        exec_hit = decode_en && hit && (cmd inside {sbcf_pkg::CMD_ACTIVE, sbcf_pkg::CMD_READ,
                   sbcf_pkg::CMD_WRITE, sbcf_pkg::CMD_BTERM, sbcf_pkg::CMD_PRECHARGE});
        state_next = state_reg;
        load       = 1'b0;
        load_val   = `SBCF_TIMER_W'(`SBCF_PRECHARGE_CYC);
        illegal    = 1'b0;
        ap_start   = 1'b0;
        unique case (state_reg)
            sbcf_pkg::BS_IDLE: begin
                if (decode_en && hit && cmd == sbcf_pkg::CMD_ACTIVE) begin
                    state_next = sbcf_pkg::BS_ACTIVATING;
                    load       = 1'b1;
                    load_val   = `SBCF_TIMER_W'(`SBCF_ACT_TO_ACCESS_CYC);
                end else if (pre_cmd && pre_all) begin
                    state_next = sbcf_pkg::BS_PRECHARGING;
                    load       = 1'b1;
                end else if (exec_hit && cmd != sbcf_pkg::CMD_PRECHARGE) begin
                    illegal = 1'b1;
                end
                // a single-bank precharge here leaves the bank alone
            end
            sbcf_pkg::BS_ACTIVATING, sbcf_pkg::BS_PRECHARGING: begin
                illegal = exec_hit || pre_cmd;
                if (t_done) begin
                    state_next = (state_reg == sbcf_pkg::BS_ACTIVATING) ?
                                 sbcf_pkg::BS_ROW_ACTIVE : sbcf_pkg::BS_IDLE;
                end
            end
            sbcf_pkg::BS_ROW_ACTIVE, sbcf_pkg::BS_READ, sbcf_pkg::BS_WRITE: begin
                if (rw_hit) begin
                    state_next = (cmd == sbcf_pkg::CMD_READ) ?
                        (auto_pre ? sbcf_pkg::BS_READ_AP  : sbcf_pkg::BS_READ) :
                        (auto_pre ? sbcf_pkg::BS_WRITE_AP : sbcf_pkg::BS_WRITE);
                end else if (pre_cmd) begin
                    state_next = sbcf_pkg::BS_PRECHARGING;
                    load       = 1'b1;
                end else if (state_reg == sbcf_pkg::BS_ROW_ACTIVE) begin
                    illegal = exec_hit;
                end else if (decode_en && hit && cmd == sbcf_pkg::CMD_BTERM) begin
                    state_next = sbcf_pkg::BS_ROW_ACTIVE;
                end else if (exec_hit) begin
                    illegal = 1'b1;
                end else if (other_burst || burst_done) begin
                    state_next = sbcf_pkg::BS_ROW_ACTIVE;
                end
            end
            sbcf_pkg::BS_READ_AP, sbcf_pkg::BS_WRITE_AP: begin
                illegal = exec_hit || pre_cmd;
                if (!ap_pre_reg && (other_burst || burst_done)) begin
                    ap_start = 1'b1;
                    load     = 1'b1;
                    // a write must also cover write recovery before precharge
                    load_val = (state_reg == sbcf_pkg::BS_WRITE_AP) ?
                        `SBCF_TIMER_W'(`SBCF_WRITE_RECOVERY_CYC + `SBCF_PRECHARGE_CYC) :
                        `SBCF_TIMER_W'(`SBCF_PRECHARGE_CYC);
                end else if (ap_pre_reg && t_done) begin
                    state_next = sbcf_pkg::BS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= sbcf_pkg::BS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ap_pre_reg <= 1'b0;
        end else if (ap_start) begin
            ap_pre_reg <= 1'b1;
        end else if (state_next == sbcf_pkg::BS_IDLE) begin
            ap_pre_reg <= 1'b0;
        end
    end

    assign state = state_reg;
endmodule : sbcf_bank
`default_nettype wire

// ### sbcf_top.sv
// four-bank command decoder with per-bank and shared state machines
`timescale 1ns/1ns
`default_nettype none
`include "sbcf_map.svh"
module sbcf_top (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_b,
    input  wire sbcf_pkg::sbcf_cmd_bus_t cmd_in,
    input  wire logic [`SBCF_NUM_BANKS-1:0] burst_done,
    input  wire logic                   sr_exit,
    input  wire logic [1:0]             cas_latency,
    output sbcf_pkg::sbcf_bank_state_t [`SBCF_NUM_BANKS-1:0] bank_state,
    output sbcf_pkg::sbcf_status_t      status,
    output logic                        illegal_cmd,
    output logic                        burst_stop,
    output logic                        deep_pd_entry,
    output logic [1:0]                  dq_owner,
    output logic                        dq_takeover
);
    sbcf_pkg::sbcf_cmd_t          cmd;
    sbcf_pkg::sbcf_glob_state_t   glob_reg, glob_next;
    logic                         cke_prev_reg, decode_en, bank_en, all_idle;
    logic                         glob_load, glob_done, glob_illegal, dpd_pattern;
    logic [`SBCF_TIMER_W-1:0]     glob_val;
    logic [`SBCF_NUM_BANKS-1:0]   idle_vec, bank_illegal, bursting;
    logic                         illegal_reg, burst_stop_reg, deep_pd_reg;
    logic [`SBCF_CAS_PIPE_DEPTH-1:0]      rd_pipe_valid_reg;
    logic [`SBCF_CAS_PIPE_DEPTH-1:0][1:0] rd_pipe_bank_reg;
    logic [1:0]                   dq_owner_reg, cl_idx;
    logic                         dq_takeover_reg, rd_accept;

    // inhibit first, then the three-line pattern
    always_comb begin
        cmd         = sbcf_pkg::CMD_INHIBIT;
        dpd_pattern = 1'b0;
        if (!cmd_in.cs_b) begin
            unique case ({cmd_in.ras_b, cmd_in.cas_b, cmd_in.we_b})
                3'h7: cmd = sbcf_pkg::CMD_NOP;
                3'h3: cmd = sbcf_pkg::CMD_ACTIVE;
                3'h5: cmd = sbcf_pkg::CMD_READ;
                3'h4: cmd = sbcf_pkg::CMD_WRITE;
                3'h6: begin
                    cmd         = sbcf_pkg::CMD_BTERM;
                    dpd_pattern = 1'b1;
                end
                3'h2: cmd = sbcf_pkg::CMD_PRECHARGE;
                3'h1: cmd = sbcf_pkg::CMD_REFRESH;
                3'h0: cmd = sbcf_pkg::CMD_LOAD_MODE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cke_prev_reg <= 1'b0;
        end else begin
            cke_prev_reg <= cmd_in.cke;
        end
    end

    // commands count only with clock enable high on both edges
    assign decode_en = cke_prev_reg && cmd_in.cke && (glob_reg != sbcf_pkg::GS_SR_EXIT_WAIT);
    assign bank_en   = decode_en && (glob_reg == sbcf_pkg::GS_NORMAL) &&
                       (cmd != sbcf_pkg::CMD_REFRESH) && (cmd != sbcf_pkg::CMD_LOAD_MODE);
    assign rd_accept = bank_en && (cmd == sbcf_pkg::CMD_READ) && !bank_illegal[cmd_in.ba];

    // banks are independent, so an idle or busy one never blocks another
    for (genvar i = 0; i < `SBCF_NUM_BANKS; i++) begin : g_bank
        sbcf_bank u_bank (
            .ref_clk     (ref_clk),
            .rst_b       (rst_b),
            .decode_en   (bank_en),
            .cmd         (cmd),
            .hit         (cmd_in.ba == 2'(i)),
            .auto_pre    (cmd_in.a10),
            .pre_all     (cmd_in.a10),
            .other_burst (bank_en && (cmd_in.ba != 2'(i)) &&
                          (cmd == sbcf_pkg::CMD_READ || cmd == sbcf_pkg::CMD_WRITE)),
            .burst_done  (burst_done[i]),
            .state       (bank_state[i]),
            .illegal     (bank_illegal[i])
        );
        assign idle_vec[i] = (bank_state[i] == sbcf_pkg::BS_IDLE);
        assign bursting[i] = (bank_state[i] == sbcf_pkg::BS_READ) ||
                             (bank_state[i] == sbcf_pkg::BS_WRITE);
    end

    assign all_idle = &idle_vec;

    sbcf_timer u_glob_timer (         // one timer shared by refresh, mode load, exit
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .load     (glob_load),
        .load_val (glob_val),
        .expire   (glob_done)
    );

    always_comb begin
        glob_next    = glob_reg;
        glob_load    = 1'b0;
        glob_val     = `SBCF_TIMER_W'(`SBCF_REFRESH_CYC);
        glob_illegal = 1'b0;
        unique case (glob_reg)
            sbcf_pkg::GS_NORMAL: begin
                if (sr_exit) begin
                    glob_next = sbcf_pkg::GS_SR_EXIT_WAIT;
                    glob_load = 1'b1;
                    glob_val  = `SBCF_TIMER_W'(`SBCF_SR_EXIT_CYC);
                end else if (decode_en && (cmd == sbcf_pkg::CMD_REFRESH ||
                                           cmd == sbcf_pkg::CMD_LOAD_MODE)) begin
                    if (!all_idle) begin
                        glob_illegal = 1'b1;
                    end else if (cmd == sbcf_pkg::CMD_REFRESH) begin
                        glob_next = sbcf_pkg::GS_REFRESHING;
                        glob_load = 1'b1;
                    end else begin
                        glob_next = sbcf_pkg::GS_MODE_ACCESS;
                        glob_load = 1'b1;
                        glob_val  = `SBCF_TIMER_W'(`SBCF_MODE_LOAD_CYC);
                    end
                end
            end
            sbcf_pkg::GS_REFRESHING, sbcf_pkg::GS_MODE_ACCESS: begin
                // executable commands here are dropped and reported
                glob_illegal = decode_en && (cmd != sbcf_pkg::CMD_NOP) &&
                               (cmd != sbcf_pkg::CMD_INHIBIT);
                if (glob_done) begin
                    glob_next = sbcf_pkg::GS_NORMAL;
                end
            end
            sbcf_pkg::GS_SR_EXIT_WAIT: begin
                if (glob_done) begin
                    glob_next = sbcf_pkg::GS_NORMAL;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            glob_reg <= sbcf_pkg::GS_NORMAL;
        end else begin
            glob_reg <= glob_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            illegal_reg <= 1'b0;
        end else begin
            illegal_reg <= (|bank_illegal) || glob_illegal;
        end
    end

    // terminate acts only on the bank that is bursting
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            burst_stop_reg <= 1'b0;
        end else begin
            burst_stop_reg <= bank_en && (cmd == sbcf_pkg::CMD_BTERM) && bursting[cmd_in.ba];
        end
    end

    // same pattern with clock enable falling enters deep power-down
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            deep_pd_reg <= 1'b0;
        end else begin
            deep_pd_reg <= cke_prev_reg && !cmd_in.cke && dpd_pattern && all_idle &&
                           (glob_reg == sbcf_pkg::GS_NORMAL);
        end
    end

    // read pipeline hands the data bus over after the CAS latency
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_pipe_valid_reg <= '0;
            rd_pipe_bank_reg  <= '0;
        end else begin
            rd_pipe_valid_reg <= {rd_pipe_valid_reg[`SBCF_CAS_PIPE_DEPTH-2:0], rd_accept};
            rd_pipe_bank_reg  <= {rd_pipe_bank_reg[`SBCF_CAS_PIPE_DEPTH-2:0], cmd_in.ba};
        end
    end

    // latency zero is not a legal setting and is treated as one
    assign cl_idx = (cas_latency == 2'h0) ? 2'h0 : cas_latency - 2'h1;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dq_owner_reg    <= 2'h0;
            dq_takeover_reg <= 1'b0;
        end else begin
            dq_takeover_reg <= rd_pipe_valid_reg[cl_idx];
            if (rd_pipe_valid_reg[cl_idx]) begin
                dq_owner_reg <= rd_pipe_bank_reg[cl_idx];
            end
        end
    end

    assign status = '{all_idle:     all_idle,
                      refreshing:   (glob_reg == sbcf_pkg::GS_REFRESHING),
                      mode_access:  (glob_reg == sbcf_pkg::GS_MODE_ACCESS),
                      sr_exit_wait: (glob_reg == sbcf_pkg::GS_SR_EXIT_WAIT),
                      decode_en:    decode_en};
    assign illegal_cmd   = illegal_reg;
    assign burst_stop    = burst_stop_reg;
    assign deep_pd_entry = deep_pd_reg;
    assign dq_owner      = dq_owner_reg;
    assign dq_takeover   = dq_takeover_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // bank 0 helpers keep the timing checks simple
    logic act0, pre0;
    assign act0 = bank_en && cmd == sbcf_pkg::CMD_ACTIVE && cmd_in.ba == 2'h0 && idle_vec[0];
    assign pre0 = bank_en && cmd == sbcf_pkg::CMD_PRECHARGE && cmd_in.ba == 2'h0 &&
                  !cmd_in.a10 && bank_state[0] == sbcf_pkg::BS_ROW_ACTIVE && !sr_exit;

    inhibit_ignored_a: assert property (cmd_in.cs_b && all_idle && !sr_exit |=> all_idle)
        else $error("inhibit changed an idle bank");
    nop_holds_a: assert property (cmd == sbcf_pkg::CMD_NOP && all_idle && !sr_exit
        |=> all_idle)
        else $error("nop changed an idle bank");
    activate_time_a: assert property (act0 |=> (bank_state[0] == sbcf_pkg::BS_ACTIVATING)[*3]
        ##1 bank_state[0] == sbcf_pkg::BS_ROW_ACTIVE)
        else $error("activating interval wrong");
    precharge_time_a: assert property (pre0 |=>
        (bank_state[0] == sbcf_pkg::BS_PRECHARGING)[*3] ##1 idle_vec[0])
        else $error("precharging interval wrong");
    idle_pre_nop_a: assert property (bank_en && cmd == sbcf_pkg::CMD_PRECHARGE &&
        !cmd_in.a10 && cmd_in.ba == 2'h0 && idle_vec[0] |=> idle_vec[0] && !illegal_cmd)
        else $error("precharge disturbed idle bank");
    refresh_time_a: assert property (glob_reg == sbcf_pkg::GS_NORMAL && !sr_exit &&
        decode_en && cmd == sbcf_pkg::CMD_REFRESH && all_idle
        |-> ##11 (!status.refreshing && $past(status.refreshing)))
        else $error("refresh interval wrong");
    mode_load_a: assert property (glob_reg == sbcf_pkg::GS_NORMAL && !sr_exit && decode_en &&
        cmd == sbcf_pkg::CMD_LOAD_MODE && all_idle
        |=> status.mode_access[*2] ##1 !status.mode_access)
        else $error("mode load interval wrong");
    busy_illegal_a: assert property (status.refreshing && decode_en &&
        cmd == sbcf_pkg::CMD_ACTIVE |=> illegal_cmd)
        else $error("command during refresh not flagged");
    cke_gate_a: assert property (!cmd_in.cke && all_idle && glob_reg == sbcf_pkg::GS_NORMAL
        && !sr_exit |=> all_idle)
        else $error("command decoded with clock enable low");
    deep_pd_a: assert property (cke_prev_reg && !cmd_in.cke && dpd_pattern && all_idle &&
        glob_reg == sbcf_pkg::GS_NORMAL |=> deep_pd_entry && !burst_stop)
        else $error("deep power-down entry missed");
    takeover_a: assert property (rd_accept && cas_latency == 2'h2 |-> ##3
        (dq_takeover && dq_owner == $past(cmd_in.ba, 3)))
        else $error("data bus takeover late or wrong bank");

    refresh_c: cover property (status.refreshing ##1 !status.refreshing);
    ap_done_c: cover property (bank_state[0] == sbcf_pkg::BS_READ_AP ##[1:20] idle_vec[0]);
    deep_pd_c: cover property (deep_pd_entry);
    takeover_c: cover property (dq_takeover && dq_owner != 2'h0);
endmodule : sbcf_top
`default_nettype wire

// ### sbcf_ctrl_model.sv
// controller model driving commands onto the bank state machine
`timescale 1ns/1ns
`default_nettype none
module sbcf_ctrl_model (
    input  wire logic                ref_clk,
    output sbcf_pkg::sbcf_cmd_bus_t  cmd_in
);
    // cke high with no-operation between commands
    initial cmd_in = 8'hb8;
    // one command per call, then nop, so each command is decoded at one edge only
    task automatic issue(input logic [3:0] c, input logic [2:0] b);
        @(posedge ref_clk);
        cmd_in <= {1'b1, c, b}; // active, access, refresh codes
        @(posedge ref_clk);
        cmd_in <= 8'hb8;
    endtask : issue
endmodule : sbcf_ctrl_model
`default_nettype wire

// ### sbcf_top_tb.sv
// self-checking bench for the bank command state machine
`timescale 1ns/1ns
`default_nettype none
module sbcf_top_tb;
    localparam logic [3:0] ACT = 4'h3, RD = 4'h5, PRE = 4'h2, REF = 4'h1, BT = 4'h6;
    logic                             ref_clk = 1'b0;
    logic                             rst_b = 1'b0;
    logic [3:0]                       burst_done = 4'h0;
    int                               n_mismatch = 0;
    int                               n_tests = 0;
    sbcf_pkg::sbcf_cmd_bus_t          cmd_in;
    sbcf_pkg::sbcf_bank_state_t [3:0] bank_state;
    sbcf_pkg::sbcf_status_t           status;
    logic                             illegal_cmd;
    logic                             burst_stop;
    logic [1:0]                       dq_owner;
    logic                             dq_takeover;
    always #4 ref_clk = ~ref_clk;
    sbcf_ctrl_model u_ctrl (.ref_clk(ref_clk), .cmd_in(cmd_in));
    sbcf_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .cmd_in(cmd_in),
        .burst_done(burst_done), .sr_exit(1'b0), .cas_latency(2'h2),
        .bank_state(bank_state), .status(status), .illegal_cmd(illegal_cmd),
        .burst_stop(burst_stop), .deep_pd_entry(), .dq_owner(dq_owner),
        .dq_takeover(dq_takeover));
    task automatic fail(input logic [3:0] g, input logic [3:0] e);
        n_mismatch++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    endtask : fail
    task automatic chk_st(input int b, input sbcf_pkg::sbcf_bank_state_t e);
        n_tests++;
        if (bank_state[b] !== e) fail({1'b0, bank_state[b]}, {1'b0, e});
    endtask : chk_st
    task automatic chk_bit(input logic g, input logic e);
        n_tests++;
        if (g !== e) fail({3'h0, g}, {3'h0, e});
    endtask : chk_bit
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    // open, read, stop, close one bank while another stays idle
    task automatic s_open_close;
        u_ctrl.issue(ACT, 3'h2); #1 chk_st(1, sbcf_pkg::BS_ACTIVATING);
        tick(2); chk_st(1, sbcf_pkg::BS_ACTIVATING);
        tick(1); chk_st(1, sbcf_pkg::BS_ROW_ACTIVE);
        chk_st(0, sbcf_pkg::BS_IDLE);
        u_ctrl.issue(RD, 3'h2); #1 chk_st(1, sbcf_pkg::BS_READ);
        u_ctrl.issue(BT, 3'h2); #1 chk_bit(burst_stop, 1'b1);
        chk_bit(dq_takeover, 1'b1);
        chk_bit(dq_owner == 2'h1, 1'b1);
        u_ctrl.issue(PRE, 3'h2); #1 chk_st(1, sbcf_pkg::BS_PRECHARGING);
        tick(2); chk_st(1, sbcf_pkg::BS_PRECHARGING);
        tick(1); chk_st(1, sbcf_pkg::BS_IDLE);
    endtask : s_open_close
    // auto precharge read closes itself after the burst ends
    task automatic s_auto_pre;
        u_ctrl.issue(ACT, 3'h4); tick(3);
        u_ctrl.issue(RD, 3'h5); #1 chk_st(2, sbcf_pkg::BS_READ_AP);
        @(posedge ref_clk);
        burst_done <= 4'h4;
        @(posedge ref_clk);
        burst_done <= 4'h0;
        tick(3); chk_st(2, sbcf_pkg::BS_IDLE);
    endtask : s_auto_pre
    // idle-bank precharge, inhibit and an unlisted read
    task automatic s_idle_cmds;
        u_ctrl.issue(PRE, 3'h0); #1 chk_st(0, sbcf_pkg::BS_IDLE);
        chk_bit(illegal_cmd, 1'b0);
        u_ctrl.issue(4'hb, 3'h0); #1 chk_st(0, sbcf_pkg::BS_IDLE);
        u_ctrl.issue(RD, 3'h0); #1 chk_bit(illegal_cmd, 1'b1);
    endtask : s_idle_cmds
    // refresh holds off an activate for the whole refresh cycle
    task automatic s_refresh;
        u_ctrl.issue(REF, 3'h0); #1 chk_bit(status.refreshing, 1'b1);
        u_ctrl.issue(ACT, 3'h0); #1 chk_bit(illegal_cmd, 1'b1);
        chk_st(0, sbcf_pkg::BS_IDLE);
        tick(7); chk_bit(status.refreshing, 1'b1);
        tick(1); chk_bit(status.refreshing, 1'b0);
    endtask : s_refresh
    // mode load holds the device for the mode load delay
    task automatic s_mode;
        u_ctrl.issue(4'h0, 3'h0); #1 chk_bit(status.mode_access, 1'b1);
        tick(1); chk_bit(status.mode_access, 1'b1);
        tick(1); chk_bit(status.mode_access, 1'b0);
    endtask : s_mode
    task automatic complete_run;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        tick(2);
        s_open_close();
        s_auto_pre();
        s_idle_cmds();
        s_refresh();
        s_mode();
        complete_run();
    end
endmodule : sbcf_top_tb
`default_nettype wire
